// *** design/dbe_pkg.sv ***
// Package for the diagnostic bus edge interrupt block.
// Assumes a single 100 MHz system clock and a plain register port.
package dbe_pkg;

  localparam int unsigned DBE_CHANNELS = 4;
  localparam int unsigned DBE_BUS_W = 8;

  // Register map
  localparam logic [31:0] DBE_CFG_STAT_OFS = 32'h4000_0204;
  localparam logic [31:0] DBE_INT_STAT_OFS = 32'h4000_0208;
  localparam logic [31:0] DBE_INT_MASK_OFS = 32'h4000_020C;

  // Field positions inside one channel byte
  localparam int unsigned DBE_FLAG_POS = 7;
  localparam int unsigned DBE_POL_POS = 6;
  localparam int unsigned DBE_BIT_LSB = 3;
  localparam int unsigned DBE_BUS_LSB = 1;
  localparam int unsigned DBE_ALLOW_POS = 0;

  localparam logic [31:0] DBE_CFG_RST = 32'h0000_0000;
  localparam logic [3:0] DBE_INT_RST = 4'h0;
  localparam logic [31:0] DBE_UNMAPPED_RD = 32'h0000_0000;

  typedef enum logic [1:0] {
    DBE_BUS_LL0 = 2'b00,
    DBE_BUS_LL1 = 2'b01,
    DBE_BUS_RF0 = 2'b10,
    DBE_BUS_RF1 = 2'b11
  } dbe_bus_sel_t;

  // One channel's settings as held in its byte
  typedef struct packed {
    logic flag;
    logic polarity;
    logic [2:0] bit_pick;
    dbe_bus_sel_t bus_pick;
    logic allow;
  } dbe_chan_t;

  // Register port request
  typedef struct packed {
    logic [31:0] addr;
    logic [31:0] wdata;
    logic wr;
    logic rd;
  } dbe_req_t;

  // The four monitored probe buses
  typedef struct packed {
    logic [7:0] link_layer_probe_bus_0;
    logic [7:0] link_layer_probe_bus_1;
    logic [7:0] radio_probe_bus_0;
    logic [7:0] radio_probe_bus_1;
  } dbe_probe_t;

endpackage

// *** design/dbe_edge_irq.sv ***
// Diagnostic bus edge interrupt: four channels watch one bit each of four probe buses.
// Assumes probe buses come from logic on sys_clk; registers reached by a plain port.
`timescale 1ns/1ps

module dbe_edge_irq
  import dbe_pkg::*;
(
  input wire logic sys_clk, // System clock, 100 MHz
  input wire logic rst_b, // Synchronous reset, active low
  input wire logic [31:0] reg_addr, // Register byte address
  input wire logic [31:0] reg_wdata, // Register write data
  input wire logic reg_wr, // Write strobe
  input wire logic reg_rd, // Read strobe
  output logic [31:0] reg_rdata, // Read data, valid the cycle after reg_rd
  input wire dbe_probe_t probes, // Diagnostic probe buses
  output logic diag_edge_interrupt // Level interrupt to the CPU
);

  dbe_req_t req;
  assign req = '{addr: reg_addr, wdata: reg_wdata, wr: reg_wr, rd: reg_rd};

  logic cfg_hit;
  logic ist_hit;
  logic imk_hit;
  assign cfg_hit = (req.addr == DBE_CFG_STAT_OFS);
  assign ist_hit = (req.addr == DBE_INT_STAT_OFS);
  assign imk_hit = (req.addr == DBE_INT_MASK_OFS);

  // Channel settings and flags, one packed byte per channel
  dbe_chan_t [DBE_CHANNELS-1:0] chan_r;
  dbe_chan_t [DBE_CHANNELS-1:0] chan_nxt;
  logic [DBE_CHANNELS-1:0] mon_prev_r;
  logic [DBE_CHANNELS-1:0] mon_prev_nxt;
  logic [DBE_CHANNELS-1:0] mon_now;
  logic [DBE_CHANNELS-1:0] edge_hit;
  logic [DBE_CHANNELS-1:0] flag_rise;
  logic [DBE_CHANNELS-1:0] pick_change;

  // Sticky interrupt status and its mask
  logic [DBE_CHANNELS-1:0] int_stat_r;
  logic [DBE_CHANNELS-1:0] int_stat_nxt;
  logic [DBE_CHANNELS-1:0] int_mask_r;
  logic [DBE_CHANNELS-1:0] int_mask_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;

  genvar g;
  generate
    for (g = 0; g < DBE_CHANNELS; g++) begin : g_chan
      logic [7:0] bus_sel;
      logic [7:0] wr_byte;
      always_comb begin
        unique case (chan_r[g].bus_pick)
          DBE_BUS_LL0: bus_sel = probes.link_layer_probe_bus_0;
          DBE_BUS_LL1: bus_sel = probes.link_layer_probe_bus_1;
          DBE_BUS_RF0: bus_sel = probes.radio_probe_bus_0;
          DBE_BUS_RF1: bus_sel = probes.radio_probe_bus_1;
        endcase
      end
      assign mon_now[g] = bus_sel[chan_r[g].bit_pick];
      assign wr_byte = req.wdata[8*g +: 8];
      // A reconfiguration would fake an edge, so the first sample after it only primes
      assign pick_change[g] = req.wr && cfg_hit &&
        (wr_byte[DBE_BIT_LSB +: 3] != chan_r[g].bit_pick ||
         wr_byte[DBE_BUS_LSB +: 2] != chan_r[g].bus_pick ||
         wr_byte[DBE_POL_POS] != chan_r[g].polarity);
      // Polarity 0 rising, 1 falling
      assign edge_hit[g] = chan_r[g].polarity ? (mon_prev_r[g] && !mon_now[g])
                                               : (!mon_prev_r[g] && mon_now[g]);
      assign flag_rise[g] = edge_hit[g] && !chan_r[g].flag;

      always_comb begin
        chan_nxt[g] = chan_r[g];
        if (req.wr && cfg_hit) begin
          chan_nxt[g].polarity = wr_byte[DBE_POL_POS];
          chan_nxt[g].bit_pick = wr_byte[DBE_BIT_LSB +: 3];
          chan_nxt[g].bus_pick = dbe_bus_sel_t'(wr_byte[DBE_BUS_LSB +: 2]);
          chan_nxt[g].allow = wr_byte[DBE_ALLOW_POS];
        end
        if (req.rd && cfg_hit) begin
          chan_nxt[g].flag = 1'b0;
        end
        if (edge_hit[g]) begin
          chan_nxt[g].flag = 1'b1;
        end
      end
    end
  endgenerate

  always_comb begin
    mon_prev_nxt = mon_now;
    int_stat_nxt = int_stat_r;
    int_mask_nxt = int_mask_r;
    if (req.wr && imk_hit) begin
      int_mask_nxt = req.wdata[DBE_CHANNELS-1:0];
    end
    if (req.wr && ist_hit) begin
      int_stat_nxt = int_stat_r & ~req.wdata[DBE_CHANNELS-1:0];
    end
    for (int i = 0; i < DBE_CHANNELS; i++) begin
      // Prime to the level an edge of the new polarity ends at, not the old one
      if (pick_change[i]) begin
        mon_prev_nxt[i] = chan_nxt[i].polarity ? 1'b0 : 1'b1;
      end
      // Only allowed channels raise a request, on each rise of their flag
      if (flag_rise[i] && chan_r[i].allow) begin
        int_stat_nxt[i] = 1'b1;
      end
    end
  end

  always_comb begin
    rdata_nxt = DBE_UNMAPPED_RD;
    if (req.rd) begin
      if (cfg_hit) begin
        rdata_nxt = chan_r;
      end else if (ist_hit) begin
        rdata_nxt = {28'h000_0000, int_stat_r};
      end else if (imk_hit) begin
        rdata_nxt = {28'h000_0000, int_mask_r};
      end
    end
  end

  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      chan_r <= DBE_CFG_RST;
      mon_prev_r <= DBE_INT_RST;
      int_stat_r <= DBE_INT_RST;
      int_mask_r <= DBE_INT_RST;
      rdata_r <= DBE_UNMAPPED_RD;
    end else begin
      chan_r <= chan_nxt;
      mon_prev_r <= mon_prev_nxt;
      int_stat_r <= int_stat_nxt;
      int_mask_r <= int_mask_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign reg_rdata = rdata_r;
  assign diag_edge_interrupt = |(int_stat_r & int_mask_r);

endmodule

// *** dv/dbe_edge_irq_checker.sv ***
// Port checker for the probe edge interrupt block.
// Assumes one clock and a master that never reads and writes together.
`timescale 1ns/1ps
module dbe_edge_irq_checker
  import dbe_pkg::*;
(
  input wire logic sys_clk, // Clock
  input wire logic rst_b, // Reset
  input wire logic [31:0] reg_addr, // Address
  input wire logic [31:0] reg_wdata, // Write data
  input wire logic reg_wr, // Write
  input wire logic reg_rd, // Read
  input wire logic [31:0] reg_rdata, // Read data
  input wire dbe_probe_t probes, // Probes
  input wire logic diag_edge_interrupt // Interrupt
);
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  sequence rd_cfg;
    reg_rd && reg_addr == DBE_CFG_STAT_OFS && $stable(probes);
  endsequence
  sequence mask_zero;
    reg_wr && reg_addr == DBE_INT_MASK_OFS && reg_wdata[3:0] == 4'h0;
  endsequence
  flag_clear_a: assert property (rd_cfg ##1 $stable(probes) ##1 rd_cfg
    |=> (reg_rdata & 32'h8080_8080) == 32'h0000_0000) else $error("flag kept");
  rd_idle_a: assert property (!reg_rd |=> reg_rdata == 32'h0000_0000)
    else $error("rdata idle");
  unmapped_a: assert property (reg_rd && reg_addr == 32'h4000_0200 |=> reg_rdata == '0)
    else $error("unmapped read");
  irq_cause_a: assert property ($rose(diag_edge_interrupt)
    |-> $past(probes) != $past(probes, 2) || $past(reg_wr)) else $error("irq no cause");
  irq_hold_a: assert property (diag_edge_interrupt && !reg_wr |=> diag_edge_interrupt)
    else $error("irq dropped");
  irq_clear_a: assert property (reg_wr && reg_addr == DBE_INT_STAT_OFS
    && reg_wdata[3:0] == 4'hF && $stable(probes) |=> !diag_edge_interrupt) else $error("clr");
  mask_off_a: assert property (mask_zero |=> !diag_edge_interrupt)
    else $error("mask off");
  mask_hold_a: assert property (mask_zero ##1 !(reg_wr && reg_addr == DBE_INT_MASK_OFS) [*6]
    |-> !diag_edge_interrupt) else $error("masked irq");
endmodule
bind dbe_edge_irq dbe_edge_irq_checker i_dbe_edge_irq_checker (.sys_clk, .rst_b, .reg_addr,
  .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .probes, .diag_edge_interrupt);

// *** dv/dbe_probe_model.sv ***
// Probe bus model: same-clock logic that toggles one probe bit on request.
// Assumes the bench raises tog for one cycle per toggle.
`timescale 1ns/1ps
module dbe_probe_model
  import dbe_pkg::*;
(
  input wire logic sys_clk, // Clock
  input wire logic tog, // Toggle request
  input wire logic [4:0] idx, // Bit to toggle
  output dbe_probe_t probes // Probe buses
);
  initial probes = '0;
  always @(posedge sys_clk) if (tog) probes[idx] <= ~probes[idx];
endmodule

// *** dv/dbe_edge_irq_tb.sv ***
// Bench for the probe edge interrupt block: reset values, every channel, masking.
// Assumes the probe model toggles one bit per request.
`timescale 1ns/1ps
module dbe_edge_irq_tb import dbe_pkg::*; ;
  logic sys_clk = 0, rst_b = 0, reg_wr = 0, reg_rd = 0, tog = 0, diag_edge_interrupt;
  logic [31:0] reg_addr = '0, reg_wdata = '0, reg_rdata, d;
  logic [4:0] idx = '0;
  dbe_probe_t probes;
  int err_count = 0, compares = 0;
  always #5 sys_clk = ~sys_clk;
  dbe_edge_irq i_dbe_edge_irq (.sys_clk, .rst_b, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
    .reg_rdata, .probes, .diag_edge_interrupt);
  dbe_probe_model i_dbe_probe_model (.sys_clk, .tog, .idx, .probes);
  task automatic chk(string n, logic [31:0] e, logic [31:0] g);
    compares++;
    if (g !== e) err_count++;
    if (g !== e) $display("CHECK FAILED %s exp %h got %h", n, e, g);
  endtask
  task automatic acc(logic w, logic [31:0] a, logic [31:0] v);
    @(posedge sys_clk);
    {reg_wr, reg_rd, reg_addr, reg_wdata} <= {w, !w, a, v};
    @(posedge sys_clk);
    {reg_wr, reg_rd} <= 2'b00;
    @(negedge sys_clk);
    d = reg_rdata;
  endtask
  task automatic t_regs();
    acc(1'b0, DBE_CFG_STAT_OFS, '0);
    chk("reset", DBE_CFG_RST, d);
    acc(1'b0, 32'h4000_0200, '0);
    chk("unmapped", DBE_UNMAPPED_RD, d);
    acc(1'b1, DBE_INT_MASK_OFS, 32'h0000_000F);
    acc(1'b0, DBE_INT_MASK_OFS, '0);
    chk("mask", 32'h0000_000F, d);
  endtask
  // Two toggles per run: one edge of each kind, bit left low for the next run
  task automatic tg(logic [4:0] b);
    for (int k = 0; k < 4; k++) begin
      @(posedge sys_clk);
      {idx, tog} <= {b, !k[0]};
    end
  endtask
  task automatic t_chan(int c, logic al, logic ex);
    logic [7:0] f;
    logic [4:0] b;
    f = {1'b0, c[0], 3'(2 * c + 1), c[1:0], al};
    b = 5'((3 - c) * 8 + 2 * c + 1);
    acc(1'b1, DBE_CFG_STAT_OFS, 32'(f) << (8 * c));
    tg(b ^ 5'h2);
    acc(1'b0, DBE_CFG_STAT_OFS, '0);
    chk("other bit", 32'(f) << (8 * c), d);
    tg(b);
    repeat (2) @(posedge sys_clk);
    @(negedge sys_clk);
    chk("irq", 32'(ex), 32'(diag_edge_interrupt));
    acc(1'b0, DBE_CFG_STAT_OFS, '0);
    chk("cfg", 32'({1'b1, f[6:0]}) << (8 * c), d);
    acc(1'b0, DBE_CFG_STAT_OFS, '0);
    chk("flag", 32'(f) << (8 * c), d);
    acc(1'b0, DBE_INT_STAT_OFS, '0);
    chk("stat", 32'(al) << c, d);
    acc(1'b1, DBE_INT_STAT_OFS, 32'h0000_000F);
    acc(1'b0, DBE_INT_STAT_OFS, '0);
    chk("stat clear", 32'h0000_0000, d);
  endtask
  task automatic test_done();
    $display("compares %0d err_count %0d", compares, err_count);
    if (err_count == 0 && compares > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge sys_clk);
    err_count++;
    test_done();
  end
  initial begin
    repeat (16) @(posedge sys_clk);
    rst_b <= 1'b1;
    t_regs();
    for (int c = 0; c < 4; c++) t_chan(c, 1'b1, 1'b1);
    t_chan(2, 1'b0, 1'b0);
    acc(1'b1, DBE_INT_MASK_OFS, 32'h0000_0000);
    t_chan(1, 1'b1, 1'b0);
    test_done();
  end
endmodule
